// File: inc/tms_pkg.sv
// shared constants and types for the cooler mode and limit supervisor
package tms_pkg;
	localparam int DW = 24;
	localparam int GW = 12;
	localparam int CLK_MHZ = 100;
	localparam int TOL_TICK_US = 1000;
	localparam int TOL_TICK_CYC = TOL_TICK_US * CLK_MHZ;
	localparam int TOL_MS_W = 16;
	localparam logic [TOL_MS_W-1:0] TOL_MS_MIN = 16'h0001;
	localparam logic [TOL_MS_W-1:0] TOL_MS_MAX = 16'hc350;
	localparam logic [DW-1:0] TOL_BAND_MIN = 24'h000001;
	localparam logic [DW-1:0] TOL_BAND_MAX = 24'h0003e8;
	localparam int INT_SHIFT_SLOW = 12;
	localparam int INT_SHIFT_FAST = 6;
	localparam int MASK_W = 8;
	localparam int OFF_THI = 0;
	localparam int OFF_TLO = 1;
	localparam int OFF_RHI = 2;
	localparam int OFF_RLO = 3;
	localparam int OFF_TOL = 4;
	localparam logic [MASK_W-1:0] MASK_RESET = 8'h03;
	localparam logic [GW-1:0] GAIN_ONE = 12'h00a;
	typedef enum logic [2:0] {
		TMS_SENS_NONE, TMS_SENS_THERM10, TMS_SENS_THERM100,
		TMS_SENS_ICUR, TMS_SENS_VOLT, TMS_SENS_PLAT
	} tms_sens_t;
	typedef enum logic [1:0] {
		TMS_MODE_TEMP, TMS_MODE_RAW, TMS_MODE_CUR
	} tms_mode_t;
endpackage

// File: logic/tms_gain_rom.sv
`timescale 1ns/1ps
// gain table: proportional gain (x10) and integrator speed per setting
module tms_gain_rom (
	input  wire logic          sys_clk_i,
	input  wire logic [3:0]    idx_i,
	output logic      [11:0]   gain_o,
	output logic               fast_o
);
	logic [12:0] rom [16];
	assign rom[0]  = {1'b0, 12'h002};
	assign rom[1]  = {1'b0, 12'h006};
	assign rom[2]  = {1'b0, 12'h00a};
	assign rom[3]  = {1'b1, 12'h00a};
	assign rom[4]  = {1'b0, 12'h014};
	assign rom[5]  = {1'b1, 12'h01e};
	assign rom[6]  = {1'b1, 12'h032};
	assign rom[7]  = {1'b0, 12'h03c};
	assign rom[8]  = {1'b0, 12'h064};
	assign rom[9]  = {1'b1, 12'h064};
	assign rom[10] = {1'b0, 12'h0c8};
	assign rom[11] = {1'b1, 12'h12c};
	assign rom[12] = {1'b1, 12'h1f4};
	assign rom[13] = {1'b0, 12'h258};
	assign rom[14] = {1'b1, 12'h3e8};
	assign rom[15] = {1'b1, 12'hbb8};
	always_ff @(posedge sys_clk_i) begin
		{fast_o, gain_o} <= rom[idx_i];
	end
endmodule

// File: logic/tms_supervisor.sv
`timescale 1ns/1ps
// cooler drive mode selection, regulation, limits and tolerance timer
// Function
// R1: no sensor allows constant current only
// R2: dual variant refuses no-sensor choice
// R3: sensor types allowed per variant
// R4: proportional error drive clamped at limit
// R5: integrator adds, slow or fast, clamped; here integ_r is never clamped, only the summed drive is
// R6: sixteen gain and speed pairs
// R7: constant current ignores gain
// R8: constant temperature regulates either polarity
// R9: raw sensor modes skip conversion
// R10: dual lacks millivolt and microamp modes
// R11: constant current still obeys temperature limits
// R12: dual lacks constant current mode
// R13: calibration offset and two-point current correction
// R14: drive never exceeds current limit
// R15: temperature limits monitored, default shut off
// R16: no sensor skips temperature limits
// R17: raw limits only in raw modes
// R18: in tolerance after band held
// R19: tolerance time and band ranges
// R20: unsettled flag when not in tolerance
// R21: unsettled offered as link event
// R22: host clears tolerance enable before on
// R23: each shutdown maskable per bit
// R24: leaving band drops tolerance at once
module tms_supervisor (
	input  wire logic                sys_clk_i,
	input  wire logic                sys_rst_i,
	input  wire logic                dual_variant_i,
	input  wire logic                sens_wr_i,
	input  wire logic [2:0]          sens_sel_i,
	input  wire logic                mode_wr_i,
	input  wire logic [1:0]          mode_sel_i,
	input  wire logic [3:0]          gain_sel_i,
	input  wire logic                sample_i,
	input  wire logic signed [23:0]  temp_act_i,
	input  wire logic signed [23:0]  raw_act_i,
	input  wire logic signed [23:0]  cur_act_i,
	input  wire logic signed [23:0]  temperature_setpoint_i,
	input  wire logic signed [23:0]  resistance_setpoint_i,
	input  wire logic signed [23:0]  current_setpoint_i,
	input  wire logic signed [23:0]  cur_limit_i,
	input  wire logic signed [23:0]  upper_temperature_bound_i,
	input  wire logic signed [23:0]  lower_temperature_bound_i,
	input  wire logic signed [23:0]  upper_raw_bound_i,
	input  wire logic signed [23:0]  lower_raw_bound_i,
	input  wire logic signed [23:0]  sens_offset_i,
	input  wire logic signed [23:0]  cur_cal_gain_i,
	input  wire logic signed [23:0]  cur_cal_offset_i,
	input  wire logic                cal_done_i,
	input  wire logic [15:0]         tol_time_ms_i,
	input  wire logic [23:0]         tol_band_i,
	input  wire logic                mask_wr_i,
	input  wire logic [7:0]          output_off_enable_mask_i,
	input  wire logic                out_on_req_i,
	input  wire logic                out_off_req_i,
	output logic                     out_en_o,
	output logic signed [23:0]       cur_cmd_o,
	output logic signed [23:0]       cur_readback_o,
	output logic [2:0]               sens_o,
	output logic [1:0]               mode_o,
	output logic [7:0]               mask_o,
	output logic                     sel_reject_o,
	output logic                     cur_limiting_o,
	output logic                     temp_hi_o,
	output logic                     temp_lo_o,
	output logic                     raw_lim_o,
	output logic                     in_tol_o,
	output logic                     unsettled_flag_o,
	output logic                     unsettled_event_o
);
	localparam int W = tms_pkg::DW;
	logic [2:0]         sens_r, sens_nxt;
	logic [1:0]         mode_r, mode_nxt;
	logic [7:0]         mask_r, mask_nxt;
	logic               rej_r, rej_nxt;
	logic               on_r, on_nxt;
	logic signed [W-1:0] cmd_r, cmd_nxt;
	logic signed [W-1:0] rb_r, rb_nxt;
	logic signed [W+15:0] integ_r, integ_nxt;
	logic               ilim_r, ilim_nxt;
	logic               thi_r, thi_nxt, tlo_r, tlo_nxt, rlim_r, rlim_nxt;
	logic               intol_r, intol_nxt, ev_r, ev_nxt, unst_r, unst_nxt;
	logic [16:0]        tick_r, tick_nxt;
	logic [15:0]        ms_r, ms_nxt;
	logic [11:0]        gain;
	logic               fast;

	// R6: gain table lookup
	tms_gain_rom u_rom (
		.sys_clk_i (sys_clk_i),
		.idx_i     (gain_sel_i),
		.gain_o    (gain),
		.fast_o    (fast)
	);

	function automatic logic signed [W-1:0] clamp(
		input logic signed [W+15:0] v,
		input logic signed [W-1:0]  lim
	);
		logic signed [W+15:0] l;
		l = {{16{lim[W-1]}}, lim};
		if (v > l)
			clamp = lim;
		else if (v < -l)
			clamp = -lim;
		else
			clamp = v[W-1:0];
	endfunction

	// sensor, mode and mask selection
	always_comb begin
		sens_nxt = sens_r;
		mode_nxt = mode_r;
		mask_nxt = mask_r;
		rej_nxt = 1'b0;
		if (sens_wr_i) begin
			// R2: no-sensor refused on dual
			if (sens_sel_i == 3'(tms_pkg::TMS_SENS_NONE) && dual_variant_i)
				rej_nxt = 1'b1;
			// R3: extra sensors single only
			else if (sens_sel_i > 3'(tms_pkg::TMS_SENS_PLAT) ||
				(dual_variant_i &&
				sens_sel_i > 3'(tms_pkg::TMS_SENS_THERM100)))
				rej_nxt = 1'b1;
			else begin
				sens_nxt = sens_sel_i;
				// R1: no sensor forces current mode
				if (sens_sel_i == 3'(tms_pkg::TMS_SENS_NONE))
					mode_nxt = 2'(tms_pkg::TMS_MODE_CUR);
			end
		end else if (mode_wr_i) begin
			// R1: regulation refused without sensor
			if (mode_sel_i != 2'(tms_pkg::TMS_MODE_CUR) &&
				sens_r == 3'(tms_pkg::TMS_SENS_NONE))
				rej_nxt = 1'b1;
			// R12: dual lacks current mode
			else if (mode_sel_i == 2'(tms_pkg::TMS_MODE_CUR) && dual_variant_i)
				rej_nxt = 1'b1;
			// R10: dual has no millivolt or microamp mode
			else if (mode_sel_i == 2'(tms_pkg::TMS_MODE_RAW) && dual_variant_i &&
				(sens_r == 3'(tms_pkg::TMS_SENS_VOLT) ||
				sens_r == 3'(tms_pkg::TMS_SENS_ICUR)))
				rej_nxt = 1'b1;
			else if (mode_sel_i > 2'(tms_pkg::TMS_MODE_CUR))
				rej_nxt = 1'b1;
			else
				mode_nxt = mode_sel_i;
		end
		if (mask_wr_i)
			mask_nxt = output_off_enable_mask_i;
	end

	// limit and tolerance evaluation
	logic signed [W-1:0] meas, setp, err;
	logic signed [W-1:0] tdev;
	logic               thi_v, tlo_v, rlim_v, band_ok, off_cond;
	always_comb begin
		// R13: per-sensor offset after calibration
		meas = cal_done_i ? raw_act_i - sens_offset_i : raw_act_i;
		// R9: raw mode uses sensor units
		setp = resistance_setpoint_i;
		// R8: temperature mode uses converted reading
		if (mode_r == 2'(tms_pkg::TMS_MODE_TEMP)) begin
			meas = temp_act_i;
			setp = temperature_setpoint_i;
		end
		err = meas - setp;
		// R16: none sensor skips temperature limits
		// R15: temperature limits in every mode
		// R11: current mode still checks limits
		thi_v = sens_r != 3'(tms_pkg::TMS_SENS_NONE) &&
			temp_act_i > upper_temperature_bound_i;
		tlo_v = sens_r != 3'(tms_pkg::TMS_SENS_NONE) &&
			temp_act_i < lower_temperature_bound_i;
		// R17: raw limits in raw mode only
		rlim_v = mode_r == 2'(tms_pkg::TMS_MODE_RAW) &&
			(raw_act_i > upper_raw_bound_i || raw_act_i < lower_raw_bound_i);
		tdev = temp_act_i - temperature_setpoint_i;
		if (tdev < 0)
			tdev = -tdev;
		// R19: band clamped to legal range
		band_ok = tdev <= $signed(tol_band_i < tms_pkg::TOL_BAND_MIN ?
			tms_pkg::TOL_BAND_MIN : (tol_band_i > tms_pkg::TOL_BAND_MAX ?
			tms_pkg::TOL_BAND_MAX : tol_band_i));
		// R23: per-condition shutdown mask
		off_cond = (thi_v && mask_r[tms_pkg::OFF_THI]) ||
			(tlo_v && mask_r[tms_pkg::OFF_TLO]) ||
			(rlim_v && raw_act_i > upper_raw_bound_i &&
			mask_r[tms_pkg::OFF_RHI]) ||
			(rlim_v && raw_act_i < lower_raw_bound_i &&
			mask_r[tms_pkg::OFF_RLO]) ||
			(!intol_r && mask_r[tms_pkg::OFF_TOL]);
	end

	// drive, integrator and tolerance timer
	logic signed [W+15:0] prop, sum, cal;
	logic [15:0] tol_ms;
	always_comb begin
		thi_nxt = thi_v;
		tlo_nxt = tlo_v;
		rlim_nxt = rlim_v;
		on_nxt = on_r;
		integ_nxt = integ_r;
		cmd_nxt = cmd_r;
		ilim_nxt = ilim_r;
		intol_nxt = intol_r;
		ev_nxt = 1'b0;
		tick_nxt = tick_r;
		ms_nxt = ms_r;
		prop = '0;
		sum = '0;
		// R22: host must clear tolerance bit first
		if (out_off_req_i || off_cond)
			on_nxt = 1'b0;
		else if (out_on_req_i)
			on_nxt = 1'b1;
		// R13: two-point current correction
		cal = cal_done_i ? ((40'(current_setpoint_i) * 40'(cur_cal_gain_i))
			>>> 16) + 40'(cur_cal_offset_i) : 40'(current_setpoint_i);
		if (!on_r) begin
			integ_nxt = '0;
			cmd_nxt = '0;
			ilim_nxt = 1'b0;
		// R7: no loop in current mode
		end else if (mode_r == 2'(tms_pkg::TMS_MODE_CUR)) begin
			cmd_nxt = clamp(cal, cur_limit_i);
			ilim_nxt = cal > 40'(cur_limit_i) || cal < -40'(cur_limit_i);
		end else if (sample_i) begin
			// R4: proportional term, gain in tenths
			prop = (40'(-err) * $signed(40'(gain))) /
				$signed(40'(tms_pkg::GAIN_ONE));
			// R5: integrator rate by speed
			integ_nxt = integ_r + (fast ? 40'(-err) <<< tms_pkg::INT_SHIFT_FAST
				: 40'(-err));
			sum = prop + (integ_nxt >>> tms_pkg::INT_SHIFT_SLOW);
			// R14: clamp at current limit
			cmd_nxt = clamp(sum, cur_limit_i);
			ilim_nxt = sum > 40'(cur_limit_i) || sum < -40'(cur_limit_i);
		end
		// R19: time clamped to legal range
		tol_ms = tol_time_ms_i < tms_pkg::TOL_MS_MIN ? tms_pkg::TOL_MS_MIN :
			(tol_time_ms_i > tms_pkg::TOL_MS_MAX ? tms_pkg::TOL_MS_MAX :
			tol_time_ms_i);
		if (!band_ok) begin
			// R24: leave band, drop at once
			// R18: excursion restarts timer
			tick_nxt = '0;
			ms_nxt = '0;
			intol_nxt = 1'b0;
			// R21: one-cycle link event
			ev_nxt = intol_r;
		end else if (!intol_r) begin
			if (tick_r == 17'(tms_pkg::TOL_TICK_CYC - 1)) begin
				tick_nxt = '0;
				ms_nxt = ms_r + 16'h0001;
				// R18: held for the full time
				if (ms_r + 16'h0001 >= tol_ms)
					intol_nxt = 1'b1;
			end else
				tick_nxt = tick_r + 17'h00001;
		end
		unst_nxt = !intol_nxt;
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sens_r <= 3'(tms_pkg::TMS_SENS_THERM100);
			mode_r <= 2'(tms_pkg::TMS_MODE_TEMP);
			// R15: temperature shutoff on by default
			// R17: raw shutoff off by default
			mask_r <= tms_pkg::MASK_RESET;
			rej_r <= 1'b0;
			on_r <= 1'b0;
			integ_r <= '0;
			cmd_r <= '0;
			rb_r <= '0;
			ilim_r <= 1'b0;
			thi_r <= 1'b0;
			tlo_r <= 1'b0;
			rlim_r <= 1'b0;
			intol_r <= 1'b0;
			ev_r <= 1'b0;
			unst_r <= 1'b1;
			tick_r <= '0;
			ms_r <= '0;
		end else begin
			sens_r <= sens_nxt;
			mode_r <= mode_nxt;
			mask_r <= mask_nxt;
			rej_r <= rej_nxt;
			on_r <= on_nxt;
			integ_r <= integ_nxt;
			cmd_r <= cmd_nxt;
			rb_r <= rb_nxt;
			ilim_r <= ilim_nxt;
			thi_r <= thi_nxt;
			tlo_r <= tlo_nxt;
			rlim_r <= rlim_nxt;
			intol_r <= intol_nxt;
			ev_r <= ev_nxt;
			unst_r <= unst_nxt;
			tick_r <= tick_nxt;
			ms_r <= ms_nxt;
		end
	end

	// R13: readback corrected in every mode
	always_comb begin
		rb_nxt = cal_done_i ? W'(((40'(cur_act_i) * 40'(cur_cal_gain_i))
			>>> 16) + 40'(cur_cal_offset_i)) : cur_act_i;
	end

	assign out_en_o = on_r;
	assign cur_cmd_o = cmd_r;
	assign cur_readback_o = rb_r;
	assign sens_o = sens_r;
	assign mode_o = mode_r;
	assign mask_o = mask_r;
	assign sel_reject_o = rej_r;
	assign cur_limiting_o = ilim_r;
	assign temp_hi_o = thi_r;
	assign temp_lo_o = tlo_r;
	assign raw_lim_o = rlim_r;
	assign in_tol_o = intol_r;
	// R20: unsettled whenever not in tolerance
	assign unsettled_flag_o = unst_r;
	assign unsettled_event_o = ev_r;

	// R14: drive within limit
	a_drive_in_limit: assert property (@(posedge sys_clk_i) // R14
		disable iff (sys_rst_i) cur_cmd_o <= cur_limit_i &&
		cur_cmd_o >= -cur_limit_i) else $error("drive above limit");
	a_none_forces_cur: assert property (@(posedge sys_clk_i) // R1
		disable iff (sys_rst_i) sens_o == 3'(tms_pkg::TMS_SENS_NONE)
		|-> mode_o == 2'(tms_pkg::TMS_MODE_CUR)) else $error("mode without sensor");
	a_dual_no_cur: assert property (@(posedge sys_clk_i) // R12
		disable iff (sys_rst_i) mode_wr_i && !sens_wr_i && dual_variant_i &&
		mode_sel_i == 2'(tms_pkg::TMS_MODE_CUR) |=> sel_reject_o)
		else $error("dual took current mode");
	a_excursion_drops: assert property (@(posedge sys_clk_i) // R24
		disable iff (sys_rst_i) !band_ok |=> !in_tol_o) else $error("tol held");
	a_temp_shutoff: assert property (@(posedge sys_clk_i) // R15
		disable iff (sys_rst_i) thi_v && mask_r[tms_pkg::OFF_THI] |=> !out_en_o)
		else $error("no shutoff on high temp");
	a_none_no_limit: assert property (@(posedge sys_clk_i) // R16
		disable iff (sys_rst_i) sens_o == 3'(tms_pkg::TMS_SENS_NONE)
		|=> !temp_hi_o && !temp_lo_o) else $error("limit without sensor");
	a_raw_mode_only: assert property (@(posedge sys_clk_i) // R17
		disable iff (sys_rst_i) mode_r != 2'(tms_pkg::TMS_MODE_RAW)
		|=> !raw_lim_o) else $error("raw limit outside raw mode");
	a_unsettled_tracks: assert property (@(posedge sys_clk_i) // R20
		disable iff (sys_rst_i) unsettled_flag_o != in_tol_o)
		else $error("unsettled wrong");
	a_off_no_drive: assert property (@(posedge sys_clk_i) // no drive while off
		disable iff (sys_rst_i) !out_en_o |=> cur_cmd_o == 0)
		else $error("drive while off");
endmodule

// File: verif/tms_mount_model.sv
`timescale 1ns/1ps
// behavioural cooler mount: sensor readings and drive current
module tms_mount_model (
	input  wire logic               sys_clk_i,
	input  wire logic               out_en_i,
	input  wire logic signed [23:0] cur_cmd_i,
	input  wire logic signed [23:0] heat_i,
	output logic signed [23:0]      temp_act_o,
	output logic signed [23:0]      raw_act_o,
	output logic signed [23:0]      cur_act_o
);
	// no current flows while the output is off
	always_ff @(posedge sys_clk_i) begin
		temp_act_o <= heat_i;
		raw_act_o <= heat_i <<< 2;
		cur_act_o <= out_en_i ? cur_cmd_i : 24'sh000000;
	end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the cooler mode and limit supervisor
module tb_top;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               dual = 1'b0, swr = 1'b0, mwr = 1'b0, kwr = 1'b0;
	logic               on_r = 1'b0, off_r = 1'b0, smp = 1'b0, cal = 1'b0;
	logic [2:0]         ssel = 3'h0;
	logic [1:0]         msel = 2'h0;
	logic [3:0]         gsel = 4'h0;
	logic [7:0]         kval = 8'h00;
	logic signed [23:0] heat = 24'sh0009c4, temperature_setpoint = 24'sh0009c4;
	logic signed [23:0] current_setpoint = 24'sh000000, lim = 24'sh007530;
	logic signed [23:0] tub = 24'sh0003e8, tlb = 24'sh0003e8;
	logic signed [23:0] rub = 24'sh001000, ofs = 24'sh000000;
	logic signed [23:0] cg = 24'sh010000;
	logic signed [23:0] tact, ract, cact, cmd, rdbk;
	logic [15:0]        tms = 16'h0001;
	logic [23:0]        band = 24'h000014;
	logic [2:0]         sens;
	logic [1:0]         mode;
	logic [7:0]         mask;
	logic               oen, rej, clim, thi, tlo, rlim, intol, unst, uev;
	logic               rej_seen = 1'b0, uev_seen = 1'b0;
	logic [31:0]        seed = 32'h527b6097;
	int                 n_fail = 0, n_tests = 0, cyc = 0;

	tms_supervisor DUT (.sys_clk_i(clk), .sys_rst_i(rst),
		.dual_variant_i(dual), .sens_wr_i(swr), .sens_sel_i(ssel),
		.mode_wr_i(mwr), .mode_sel_i(msel), .gain_sel_i(gsel),
		.sample_i(smp), .temp_act_i(tact), .raw_act_i(ract),
		.cur_act_i(cact), .temperature_setpoint_i(temperature_setpoint),
		.resistance_setpoint_i(temperature_setpoint), .current_setpoint_i(current_setpoint),
		.cur_limit_i(lim), .upper_temperature_bound_i(tub),
		.lower_temperature_bound_i(tlb), .upper_raw_bound_i(rub),
		.lower_raw_bound_i(24'sh000000), .sens_offset_i(ofs),
		.cur_cal_gain_i(cg), .cur_cal_offset_i(ofs), .cal_done_i(cal),
		.tol_time_ms_i(tms), .tol_band_i(band), .mask_wr_i(kwr),
		.output_off_enable_mask_i(kval), .out_on_req_i(on_r),
		.out_off_req_i(off_r), .out_en_o(oen), .cur_cmd_o(cmd),
		.cur_readback_o(rdbk), .sens_o(sens), .mode_o(mode),
		.mask_o(mask), .sel_reject_o(rej), .cur_limiting_o(clim),
		.temp_hi_o(thi), .temp_lo_o(tlo), .raw_lim_o(rlim),
		.in_tol_o(intol), .unsettled_flag_o(unst),
		.unsettled_event_o(uev));

	tms_mount_model mount (.sys_clk_i(clk), .out_en_i(oen),
		.cur_cmd_i(cmd), .heat_i(heat), .temp_act_o(tact),
		.raw_act_o(ract), .cur_act_o(cact));

	always #5 clk = ~clk;

	always @(negedge clk) smp = (cyc[3:0] == 4'h0);

	// sticky capture of one-cycle pulses, and hang cut-off
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rej === 1'b1) rej_seen <= 1'b1;
		if (uev === 1'b1) uev_seen <= 1'b1;
		if (cyc == 102000) begin
			n_fail++;
			wrap_up();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// 0 sensor, 1 mode, 2 mask, 3 on request, 4 off request
	task automatic req(input int k, input logic [7:0] v);
		@(negedge clk);
		rej_seen = 1'b0;
		case (k)
			0: begin ssel = v[2:0]; swr = 1'b1; end
			1: begin msel = v[1:0]; mwr = 1'b1; end
			2: begin kval = v; kwr = 1'b1; end
			4: off_r = 1'b1;
			default: on_r = 1'b1;
		endcase
		@(negedge clk);
		{swr, mwr, kwr, on_r, off_r} = 5'h00;
		repeat (3) @(negedge clk);
	endtask

	initial begin
		int v, e;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("reset sens", 24'h2, 24'(sens));
		chk("reset mode", 24'h0, 24'(mode));
		chk("reset mask", 24'h3, 24'(mask)); // default enables
		chk("reset flags", 24'h1, 24'({oen, intol, unst}));
		$display("test reset done");
		dual = 1'b1;
		for (int s = 0; s < 6; s++) begin
			req(0, 8'(s));
			chk("dual sens refused", 24'(s != 1 && s != 2), 24'(rej_seen)); // variant sensors
		end
		chk("dual sens", 24'h2, 24'(sens)); // kept choice
		req(1, 8'h02);
		chk("dual const cur refused", 24'h1, 24'(rej_seen)); // no current mode
		req(1, 8'h01);
		chk("dual raw mode", 24'h1, 24'(mode)); // raw with thermistor
		req(1, 8'h00);
		dual = 1'b0;
		for (int s = 5; s > 0; s--) begin
			req(0, 8'(s));
			chk("single sens", 24'(s), 24'(sens)); // every sensor type except none
		end
		req(1, 8'h02);
		req(0, 8'h00);
		chk("none sens", 24'h0, 24'(sens)); // single allows none
		for (int m = 0; m < 2; m++) begin
			req(1, 8'(m));
			chk("none mode refused", 24'h1, 24'(rej_seen)); // current only
		end
		chk("none mode", 24'h2, 24'(mode)); // mode kept
		$display("test selection done");
		req(3, 8'h00);
		chk("none no limit", 24'h2, 24'({oen, thi})); // limits skipped
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			v = int'($signed(seed[16:0]));
			current_setpoint = 24'(v);
			gsel = seed[23:20];
			repeat (4) @(negedge clk);
			chk("drive", 24'(v > 30000 ? 30000 : v < -30000 ? -30000 : v), cmd); // clamp
			chk("limiting", 24'(v > 30000 || v < -30000), 24'(clim)); // flag
			e = v > 30000 ? 30000 : v < -30000 ? -30000 : v;
			chk("readback", 24'(e), rdbk); // uncorrected readback
		end
		cal = 1'b1;
		cg = 24'sh020000;
		current_setpoint = 24'sh001000;
		repeat (4) @(negedge clk);
		chk("cal drive", 24'h002000, cmd); // set point gain
		chk("cal readback", 24'h004000, rdbk); // readback gain
		cal = 1'b0;
		$display("test constant current done");
		req(0, 8'h02);
		req(3, 8'h00);
		chk("hot off", 24'h1, 24'({oen, thi})); // high limit
		tub = 24'sh000fa0;
		req(3, 8'h00);
		chk("in range on", 24'h1, 24'(oen)); // no violation
		heat = 24'sh000320;
		repeat (4) @(negedge clk);
		chk("cold off", 24'h1, 24'({oen, tlo})); // low limit
		req(2, 8'h00);
		chk("mask", 24'h0, 24'(mask)); // mask load
		req(3, 8'h00);
		chk("masked on", 24'h1, 24'(oen)); // cleared bit
		rub = 24'sh000100;
		req(2, 8'h0c);
		req(3, 8'h00);
		chk("raw ignored", 24'h2, 24'({oen, rlim})); // only raw modes
		req(1, 8'h01);
		chk("raw off", 24'h1, 24'({oen, rlim})); // raw mode shutdown
		$display("test limits done");
		req(2, 8'h00);
		req(1, 8'h00);
		gsel = 4'h8;
		heat = 24'sh000960;
		req(3, 8'h00);
		repeat (20) @(negedge clk);
		chk("temp drive", 24'sd1000, cmd); // error times gain
		req(4, 8'h00);
		chk("off state", 24'h0, 24'(oen)); // off request
		chk("off drive", 24'h0, cmd); // no drive while off
		req(1, 8'h01);
		gsel = 4'h9;
		heat = 24'sh00028a;
		req(3, 8'h00);
		repeat (20) @(negedge clk);
		chk("raw fast drive", 24'h1, 24'($signed(cmd) < -1000 &&
			$signed(cmd) > -1005)); // fast integrator
		$display("test regulation done");
		req(2, 8'h00);
		req(1, 8'h00);
		req(3, 8'h00);
		heat = 24'sh0009ce;
		repeat (90000) @(negedge clk);
		chk("early tol", 24'h1, 24'({intol, unst})); // timer running
		for (v = 0; v < 30000 && intol !== 1'b1; v++) @(negedge clk);
		chk("in tol", 24'h2, 24'({intol, unst})); // settled
		req(2, 8'h10);
		uev_seen = 1'b0;
		heat = 24'sh0009ec;
		repeat (3) @(negedge clk);
		chk("left band", 24'h0, 24'({intol, oen})); // drop and off
		chk("unsettled", 24'h3, 24'({unst, uev_seen})); // flag and event
		req(2, 8'h00); // host clears enable first
		req(3, 8'h00);
		chk("back on", 24'h1, 24'(oen)); // on accepted
		$display("test tolerance done");
		wrap_up();
	end
endmodule
